// *** src/eq_controller.sv ***
`timescale 1ns/100ps
module eq_controller
  import eq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  eq_link_if.host link
);
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  typedef enum {IDLE, LOW, HIGH, TAIL} ser_state_e;

  // ------------------------------------------------------------
  // bus slave and serial engine state
  // ------------------------------------------------------------
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic mode_r, mode_nxt;
  logic [REG_COUNT-1:0] frame_r, frame_nxt, echo_r, echo_nxt, tx_r, tx_nxt;
  ser_state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic sclk_r, sclk_nxt, din_r, din_nxt, enb_n_r, enb_n_nxt;
  logic so_s;
  logic start;

  // echo from the device is another clock domain
  sync2 #(.W(1)) u_echo_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(link.ser_out),
    .q(so_s)
  );

  // next values of bus and engine
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    mode_nxt = mode_r;
    frame_nxt = frame_r;
    start = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // write commits once both halves are held
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awaddr_r == CTRL_OFS) begin
        // [RULE11] mode stays low until software raises it
        mode_nxt = wdata_r[MODE_BIT];
        start = wdata_r[START_BIT];
      end else if (awaddr_r == FRAME_OFS) begin
        frame_nxt = wdata_r[REG_COUNT-1:0];
      end else if (awaddr_r != STATUS_OFS && awaddr_r != ECHO_OFS) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = '0;
      unique case (s_axi_araddr[7:0])
        CTRL_OFS: rdata_nxt[MODE_BIT] = mode_r;
        FRAME_OFS: rdata_nxt[REG_COUNT-1:0] = frame_r;
        STATUS_OFS: rdata_nxt[BUSY_BIT] = (st_r != IDLE);
        ECHO_OFS: rdata_nxt[REG_COUNT-1:0] = echo_r;
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
    arready_nxt = !rvalid_nxt;

    // serial engine; a start while busy is dropped
    st_nxt = st_r;
    cnt_nxt = cnt_r + 4'h1;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    echo_nxt = echo_r;
    sclk_nxt = sclk_r;
    din_nxt = din_r;
    enb_n_nxt = enb_n_r;
    unique case (st_r)
      IDLE: begin
        cnt_nxt = '0;
        if (start && mode_nxt) begin
          // [RULE12] enable low for the whole load
          enb_n_nxt = 1'b0;
          // [RULE20] register 21 bit goes first
          tx_nxt = frame_r;
          din_nxt = frame_r[REG_COUNT-1];
          bit_nxt = '0;
          st_nxt = LOW;
        end
      end
      LOW: begin
        if (cnt_r == 4'(SER_LOW_CYC - 1)) begin
          // [RULE13] data stood a whole low phase
          sclk_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = HIGH;
        end
      end
      HIGH: begin
        if (cnt_r == 4'(SER_HIGH_CYC - 1)) begin
          // old contents shift back out, oldest register first;
          // taken at the fall, as the echo lags the device shift by two syncs
          echo_nxt = {echo_r[REG_COUNT-2:0], so_s};
          // [RULE14] 40 ns high plus 60 ns low gives 10 MHz
          sclk_nxt = 1'b0;
          cnt_nxt = '0;
          if (bit_r == 5'(REG_COUNT - 1)) begin
            st_nxt = TAIL;
          end else begin
            bit_nxt = bit_r + 5'h01;
            tx_nxt = {tx_r[REG_COUNT-2:0], 1'b0};
            din_nxt = tx_r[REG_COUNT-2];
            st_nxt = LOW;
          end
        end
      end
      TAIL: begin
        if (cnt_r == 4'(SER_LOW_CYC - 1)) begin
          enb_n_nxt = 1'b1;
          st_nxt = IDLE;
        end
      end
    endcase
  end

  // all state registered here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      awaddr_r <= '0;
      wdata_r <= '0;
      mode_r <= 1'b0;
      frame_r <= REG_RESET;
      echo_r <= REG_RESET;
      tx_r <= REG_RESET;
      st_r <= IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sclk_r <= 1'b0;
      din_r <= 1'b0;
      enb_n_r <= 1'b1;
    end else if (ce) begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      mode_r <= mode_nxt;
      frame_r <= frame_nxt;
      echo_r <= echo_nxt;
      tx_r <= tx_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sclk_r <= sclk_nxt;
      din_r <= din_nxt;
      enb_n_r <= enb_n_nxt;
    end
  end

  // outputs from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign link.ser_clk = sclk_r;
  assign link.ser_in = din_r;
  assign link.ser_enable_n = enb_n_r;
  assign link.mode = mode_r;

endmodule : eq_controller

// *** src/eq_pkg.sv ***
// Notes on behaviour
// [RULE1] each lane: 32 serial or 18 pin levels
// [RULE2] mute lane while amplitude below threshold
// [RULE3] muted output held at common mode
// [RULE4] carrier absent follows the mute signal
// [RULE5] fixed boost, valid from first bit
// [RULE6] serial bits shift in; registers override pins
// [RULE7] serial out repeats input 21 clocks later
// [RULE8] pin word: A most, C least significant
// [RULE9] mode high allows serial programming
// [RULE10] mode low clears registers, pins rule
// [RULE11] unused serial port: hold mode low
// [RULE12] enable low only during shifting load
// [RULE13] data sampled on serial clock rising edge
// [RULE14] controller serial clock 10 to 20 MHz
// [RULE15] register 1 set selects register boost
// [RULE16] five-bit lane words, lowest register is LSB
// [RULE17] registers zero after power-up
// [RULE18] A two-state, B/C three-state, 18-entry lookup
// [RULE19] new values take effect at enable high
// [RULE20] register 21 bit first, register 1 last
package eq_pkg;

  // ------------------------------------------------------------
  // lanes and register chain
  // ------------------------------------------------------------
  localparam int LANES = 4;
  localparam int BOOST_W = 5;
  localparam int REG_COUNT = 21;
  localparam int OVERRIDE_POS = 0;
  localparam int LANE_BASE = 1;
  localparam logic [REG_COUNT-1:0] REG_RESET = 21'h000000;
  localparam int PIN_LEVEL_W = 2;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_MID = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SER_HIGH_NS = 40;
  localparam int SER_LOW_NS = 60;
  localparam int SER_HIGH_CYC = (SER_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SER_LOW_CYC = (SER_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // controller register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FRAME_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ECHO_OFS = 8'h0c;
  localparam int MODE_BIT = 0;
  localparam int START_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ternary digit value, an unused fourth code counts as high
  function automatic logic [4:0] digit(input logic [1:0] p);
    digit = (p == PIN_LOW) ? 5'h00 : (p == PIN_MID) ? 5'h01 : 5'h02;
  endfunction : digit

  // pin word to one of 18 serial levels
  function automatic logic [BOOST_W-1:0] pin_boost(input logic [1:0] a, input logic [1:0] b,
                                                    input logic [1:0] c);
    logic [4:0] idx;
    idx = ((a != PIN_LOW) ? 5'h09 : 5'h00) + 5'(digit(b) * 5'h03) + digit(c);
    case (idx)
      5'h00: pin_boost = 5'h00;
      5'h01: pin_boost = 5'h02;
      5'h02: pin_boost = 5'h04;
      5'h03: pin_boost = 5'h06;
      5'h04: pin_boost = 5'h08;
      5'h05: pin_boost = 5'h0a;
      5'h06: pin_boost = 5'h0c;
      5'h07: pin_boost = 5'h0e;
      5'h08: pin_boost = 5'h0f;
      5'h09: pin_boost = 5'h10;
      5'h0a: pin_boost = 5'h11;
      5'h0b: pin_boost = 5'h13;
      5'h0c: pin_boost = 5'h15;
      5'h0d: pin_boost = 5'h17;
      5'h0e: pin_boost = 5'h18;
      5'h0f: pin_boost = 5'h1a;
      5'h10: pin_boost = 5'h1c;
      default: pin_boost = 5'h1f;
    endcase
  endfunction : pin_boost

endpackage : eq_pkg

// *** src/eq_link_if.sv ***
`timescale 1ns/100ps
// serial programming link between controller and equalizer
interface eq_link_if;
  logic ser_clk;
  logic ser_in;
  logic ser_enable_n;
  logic mode;
  logic ser_out;

  modport device (
    input ser_clk,
    input ser_in,
    input ser_enable_n,
    input mode,
    output ser_out
  );

  modport host (
    output ser_clk,
    output ser_in,
    output ser_enable_n,
    output mode,
    input ser_out
  );
endinterface : eq_link_if

// *** src/sync2.sv ***
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  // clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage is read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule : sync2

// *** src/eq_device.sv ***
`timescale 1ns/100ps
module eq_device
  import eq_pkg::*;
#(
  parameter int AMP_W = 8
) (
  // clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // serial programming link
  eq_link_if.device link,
  // boost select pins, per lane [2]=A [1]=B [0]=C
  input wire logic [LANES-1:0][2:0][PIN_LEVEL_W-1:0] boost_select_pins,
  // amplitude detector, same clock domain
  input wire logic [AMP_W-1:0] detect_threshold,
  input wire logic [LANES-1:0][AMP_W-1:0] lane_amplitude,
  input wire logic [LANES-1:0] lane_data,
  // lane results
  output logic [LANES-1:0] lane_out,
  output logic [LANES-1:0] lane_cm_hold,
  output logic [LANES-1:0] carrier_absent,
  output logic [LANES-1:0][BOOST_W-1:0] boost_level
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (AMP_W < 1 || AMP_W > 16) begin : g_bad_amp
    $error("AMP_W must lie between 1 and 16");
  end
  if (LANE_BASE + LANES * BOOST_W != REG_COUNT) begin : g_bad_chain
    $error("register chain does not match lane words");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [3:0] link_q;
  logic [LANES-1:0][2:0][PIN_LEVEL_W-1:0] pins_q;
  logic sclk_s;
  logic din_s;
  logic enb_n_s;
  logic mode_s;

  // every link pin comes from another clock
  sync2 #(.W(4)) u_link_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d({link.ser_clk, link.ser_in, link.ser_enable_n, link.mode}),
    .q(link_q)
  );

  // strapped pins are static but still asynchronous
  sync2 #(.W(LANES * 3 * PIN_LEVEL_W)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(boost_select_pins),
    .q(pins_q)
  );

  // synchronised link levels
  assign sclk_s = link_q[3];
  assign din_s = link_q[2];
  assign enb_n_s = link_q[1];
  assign mode_s = link_q[0];

  // ------------------------------------------------------------
  // serial register chain
  // ------------------------------------------------------------
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic enb_d_r;
  logic enb_d_nxt;
  logic [REG_COUNT-1:0] shift_r;
  logic [REG_COUNT-1:0] shift_nxt;
  logic [REG_COUNT-1:0] active_r;
  logic [REG_COUNT-1:0] active_nxt;
  logic ser_out_r;
  logic ser_out_nxt;
  logic sclk_rise;
  logic enb_rise;

  // edges seen after synchronisation; data shares the same lag
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign enb_rise = enb_n_s & ~enb_d_r;

  // chain next state
  always_comb begin
    sclk_d_nxt = sclk_s;
    enb_d_nxt = enb_n_s;
    shift_nxt = shift_r;
    active_nxt = active_r;
    if (!mode_s) begin
      // [RULE10] mode low clears
      shift_nxt = REG_RESET;
      active_nxt = REG_RESET;
    end else begin
      // [RULE9] [RULE12] [RULE13] shift while enabled
      if (sclk_rise && !enb_n_s) begin
        // [RULE6] [RULE20] new bit enters register 1
        shift_nxt = {shift_r[REG_COUNT-2:0], din_s};
      end
      // [RULE19] commit on enable release
      if (enb_rise) begin
        active_nxt = shift_r;
      end
    end
    // [RULE7] register 21 drives the chain output
    ser_out_nxt = shift_nxt[REG_COUNT-1];
  end

  // chain registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // [RULE17] chain registers zero, enable history reset high
      sclk_d_r <= 1'b0;
      enb_d_r <= 1'b1;
      shift_r <= REG_RESET;
      active_r <= REG_RESET;
      ser_out_r <= 1'b0;
    end else if (ce) begin
      sclk_d_r <= sclk_d_nxt;
      enb_d_r <= enb_d_nxt;
      shift_r <= shift_nxt;
      active_r <= active_nxt;
      ser_out_r <= ser_out_nxt;
    end
  end

  assign link.ser_out = ser_out_r;

  // ------------------------------------------------------------
  // per-lane boost select and line silence
  // ------------------------------------------------------------
  logic [LANES-1:0] lane_out_r;
  logic [LANES-1:0] cm_hold_r;
  logic [LANES-1:0] absent_r;
  logic [LANES-1:0][BOOST_W-1:0] boost_r;

  for (genvar k = 0; k < LANES; k++) begin : g_lane
    logic mute;
    logic out_nxt;
    logic absent_nxt;
    logic [BOOST_W-1:0] boost_nxt;
    logic [BOOST_W-1:0] pin_level;

    // [RULE8] [RULE18] A as top digit, fixed lookup
    assign pin_level = pin_boost(pins_q[k][2], pins_q[k][1], pins_q[k][0]);

    // [RULE2] below threshold means silence
    assign mute = lane_amplitude[k] < detect_threshold;

    // lane next state
    always_comb begin
      // [RULE1] [RULE15] [RULE16] override picks the lane word
      if (active_r[OVERRIDE_POS]) begin
        boost_nxt = active_r[LANE_BASE + k * BOOST_W +: BOOST_W];
      end else begin
        boost_nxt = pin_level;
      end
      // [RULE3] muted lanes stop toggling
      out_nxt = mute ? 1'b0 : lane_data[k];
      // [RULE4] indicator straight from mute
      absent_nxt = mute;
    end

    // lane registers; a setting is static, so no settling time
    // [RULE5] fixed level applied at once
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        boost_r[k] <= '0;
        lane_out_r[k] <= 1'b0;
        cm_hold_r[k] <= 1'b1;
        absent_r[k] <= 1'b1;
      end else if (ce) begin
        boost_r[k] <= boost_nxt;
        lane_out_r[k] <= out_nxt;
        cm_hold_r[k] <= absent_nxt;
        absent_r[k] <= absent_nxt;
      end
    end
  end

  // outputs straight from flops
  assign lane_out = lane_out_r;
  assign lane_cm_hold = cm_hold_r;
  assign carrier_absent = absent_r;
  assign boost_level = boost_r;

endmodule : eq_device

// *** test/eq_link_monitor.sv ***
`timescale 1ns/100ps
module eq_link_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  input wire logic ser_clk,
  input wire logic ser_in,
  input wire logic ser_enable_n,
  input wire logic mode,
  input wire logic ser_out
);
  // ------------------------------------------------------------
  // reference chain
  // ------------------------------------------------------------
  logic clk_q_r;
  logic [4:0] rise_cnt_r;
  logic [20:0] chain_r;

  // rises counted per load; chain mirrors the device, cleared by mode low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_q_r <= 1'b0;
      rise_cnt_r <= 5'h00;
      chain_r <= 21'h000000;
    end else begin
      clk_q_r <= ser_clk;
      if (ser_enable_n)
        rise_cnt_r <= 5'h00;
      else if (ser_clk && !clk_q_r)
        rise_cnt_r <= rise_cnt_r + 5'h01;
      if (!mode)
        chain_r <= 21'h000000;
      else if (ser_clk && !clk_q_r && !ser_enable_n)
        chain_r <= {chain_r[19:0], ser_in};
    end
  end

  // ------------------------------------------------------------
  // link properties
  // ------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  clk_idle_a: assert property (ser_enable_n |-> !ser_clk)
    else $error("serial clock moved outside a load");
  enable_setup_a: assert property ($fell(ser_enable_n) |-> !ser_clk[*3] ##1 ser_clk)
    else $error("first clock rise not three cycles after enable");
  clk_high_a: assert property ($rose(ser_clk) |-> ser_clk[*2] ##1 !ser_clk)
    else $error("serial clock high phase wrong");
  clk_low_a: assert property ($fell(ser_clk) |-> !ser_clk[*3] ##1 (ser_clk || ser_enable_n))
    else $error("serial clock low phase wrong");
  data_hold_a: assert property (ser_clk |-> $stable(ser_in))
    else $error("serial data changed around clock rise");
  bit_count_a: assert property ($rose(ser_enable_n) |-> rise_cnt_r == 5'h15)
    else $error("load did not carry 21 bits");
  chain_delay_a: assert property ($rose(ser_clk) |-> ser_out == chain_r[20])
    else $error("chain output not input delayed 21 clocks");
  out_still_a: assert property (ser_enable_n && mode && $past(mode) |-> $stable(ser_out))
    else $error("chain output moved with enable high");
  mode_clear_a: assert property ($fell(mode) |-> ##[1:5] !ser_out ##1 !ser_out)
    else $error("chain not cleared by mode low");
endmodule : eq_link_monitor

// *** test/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import eq_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed {logic [1:0] a; logic [1:0] b; logic [1:0] c; logic [4:0] lvl;} row_s;
  localparam logic [4:0] LVL [18] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h0f,
                                      5'h10, 5'h11, 5'h13, 5'h15, 5'h17, 5'h18, 5'h1a, 5'h1c, 5'h1f};
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [LANES-1:0][2:0][1:0] pins;
  logic [7:0] thr;
  logic [LANES-1:0][7:0] amp;
  logic [LANES-1:0] data, lane_out, cm_hold, absent;
  logic [LANES-1:0][BOOST_W-1:0] boost, pin_exp;
  row_s rows [18];
  int mismatches, total_checks;

  eq_link_if link ();
  eq_controller eq_controller_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  eq_device eq_device_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(link), .boost_select_pins(pins),
    .detect_threshold(thr), .lane_amplitude(amp), .lane_data(data), .lane_out(lane_out),
    .lane_cm_hold(cm_hold), .carrier_absent(absent), .boost_level(boost));
  eq_link_monitor eq_link_monitor_inst (.aclk(aclk), .aresetn(aresetn), .ser_clk(link.ser_clk),
    .ser_in(link.ser_in), .ser_enable_n(link.ser_enable_n), .mode(link.mode), .ser_out(link.ser_out));

  // free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // one load; boost must not move before enable returns high
  task automatic run_frame(input logic [20:0] f, input logic [20:0] old);
    logic [31:0] d;
    logic [1:0] r;
    axi_write(FRAME_OFS, {11'h000, f}, r);
    axi_write(CTRL_OFS, 32'h00000003, r);
    repeat (40) @(posedge aclk);
    check(32'(boost), 32'(pin_exp), "boost during load");
    do axi_read(STATUS_OFS, d, r); while (d[BUSY_BIT] === 1'b1);
    repeat (8) @(posedge aclk);
    axi_read(ECHO_OFS, d, r);
    check(d, {11'h000, old}, "chain echo");
  endtask : run_frame

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [20:0] f1, f2;
    int j;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    pins = '0;
    thr = 8'h10;
    amp = {LANES{8'h80}};
    data = 4'h0;
    f1 = {5'h15, 5'h0a, 5'h1f, 5'h01, 1'b0};
    f2 = {5'h13, 5'h1c, 5'h10, 5'h1e, 1'b1};
    for (int i = 0; i < 18; i++) rows[i] = '{2'(i / 9) * 2'h2, 2'((i / 3) % 3), 2'(i % 3), LVL[i]};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // every pin word, lanes offset so each lane differs
    for (int i = 0; i < 18; i++) begin
      for (int k = 0; k < LANES; k++) begin
        j = (i + 5 * k) % 18;
        pins[k] <= {rows[j].a, rows[j].b, rows[j].c};
        pin_exp[k] = rows[j].lvl;
      end
      repeat (6) @(posedge aclk);
      check(32'(boost), 32'(pin_exp), "pin boost");
    end
    // mute and carrier absent against threshold, equal counts as present
    thr <= 8'h40;
    amp <= {8'h00, 8'h41, 8'h40, 8'h3f};
    data <= 4'h5;
    repeat (6) @(posedge aclk);
    check(32'(absent), 32'h9, "carrier absent");
    check(32'(cm_hold), 32'h9, "common mode hold");
    check(32'(lane_out), 32'h4, "lane output");
    // serial loads: override clear, then set
    axi_write(CTRL_OFS, 32'h00000001, r);
    repeat (6) @(posedge aclk);
    run_frame(f1, 21'h000000);
    check(32'(boost), 32'(pin_exp), "override clear");
    run_frame(f2, f1);
    check(32'(boost), {12'h000, f2[20:1]}, "register boost");
    // mode low clears, start then refused
    axi_write(CTRL_OFS, 32'h00000000, r);
    repeat (8) @(posedge aclk);
    check(32'(boost), 32'(pin_exp), "mode low boost");
    axi_write(CTRL_OFS, 32'h00000002, r);
    repeat (10) @(posedge aclk);
    check(32'(link.ser_enable_n), 32'h1, "start with mode low");
    axi_write(CTRL_OFS, 32'h00000001, r);
    repeat (6) @(posedge aclk);
    run_frame(f2, 21'h000000);
    check(32'(boost), {12'h000, f2[20:1]}, "reload boost");
    // unmapped address
    axi_write(8'h10, 32'h0000ffff, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped write");
    axi_read(8'h10, d, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped read");
    check(d, 32'h00000000, "unmapped data");
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    check(32'(boost), 32'h0, "boost in reset");
    check(32'(absent), 32'hf, "absent in reset");
    check(32'({link.mode, link.ser_enable_n}), 32'h1, "link in reset");
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    final_report();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report();
  end
endmodule : tb_top
